// [verilog/radio_fifo_pkg.sv]
package radio_fifo_pkg;
  // register locations on the configuration port
  localparam logic [4:0] addr_fifo_size_threshold     = 5'h0c;
  localparam logic [4:0] addr_irq_pin_mapping         = 5'h0d;
  localparam logic [4:0] addr_irq_fifo_control_status = 5'h0e;

  // reset values
  localparam logic [7:0] rst_fifo_size_threshold      = 8'h00;
  localparam logic [7:0] rst_irq_pin_mapping          = 8'h00;
  localparam logic [7:0] rst_irq_fifo_control_status  = 8'h00;

  // fifo_size_threshold fields
  localparam int size_len_lsb   = 6;
  localparam int size_thr_msb   = 5;
  localparam logic [6:0] fifo_unit_bytes = 7'h10;

  // irq_pin_mapping fields
  localparam int map_a_rx_lsb   = 6;
  localparam int map_b_rx_lsb   = 4;
  localparam int map_a_tx_bit   = 3;
  localparam int map_b_tx_bit   = 2;

  // irq_fifo_control_status fields
  localparam int ctl_fill_manual = 7;
  localparam int ctl_fill_start  = 6;
  localparam int ctl_tx_done     = 5;
  localparam int ctl_overflow    = 4;
  localparam int ctl_rssi_enable = 3;
  localparam int ctl_rssi_level  = 2;
  localparam int ctl_pll_unlock  = 1;
  localparam int ctl_lock_off    = 0;

  // operating_mode_field codes
  localparam logic [2:0] mode_standby  = 3'h1;
  localparam logic [2:0] mode_synth    = 3'h2;
  localparam logic [2:0] mode_receive  = 3'h3;
  localparam logic [2:0] mode_transmit = 3'h4;

  // serial port framing
  localparam int spi_read_bit = 7;
  localparam logic [3:0] spi_hdr_last  = 4'h7;
  localparam logic [3:0] spi_data_last = 4'hf;
  localparam logic [3:0] spi_rd_load   = 4'h8;
endpackage : radio_fifo_pkg

// [verilog/radio_fifo_irq.sv]
// Summary of operation
// - length code selects 16, 32, 48, 64 bytes
// - threshold is six-bit field plus one
// - receive event when count at or above threshold
// - transmit event when count at or below threshold
// - not-empty and full flags exported
// - in automatic fill, receive storage starts only after start pattern
// - writing control bit 6 arms pattern detection
// - bit 7 picks automatic or bit-6 fill
// - status bit 5 reads transmission done
// - overflow flag; writing one resets fifo
// - bit 3 enables signal-strength event; bit 2 level
// - bit 1 unlock status; bit 0 forces lock pin
// - second output selector in packet receive
// - first output in transmit: threshold or not-empty
// - second output in transmit: full or stop
// - stop event at final bit; host waits
// - pulse per received byte in buffered receive
// - host walks modes, checks lock before radio
// - packet transmit adds preamble, pattern, checksum
// - packet receive filters by address policy
module radio_fifo_irq #(
  parameter int DEPTH = 64
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       spi_clk,
  input  wire logic       nss_config_n,
  input  wire logic       nss_data_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  output logic            host_interrupt_a,
  output logic            host_interrupt_b,
  output logic            lock_pin,
  input  wire logic [2:0] operating_mode_field,
  input  wire logic       packet_mode,
  input  wire logic       standby_fifo_read,
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       start_pattern_detect,
  input  wire logic [7:0] own_address,
  input  wire logic [1:0] address_filter,
  input  wire logic       rx_address_valid,
  input  wire logic [7:0] rx_address,
  output logic            address_accept,
  input  wire logic       crc_ok,
  input  wire logic       data_ready,
  input  wire logic       signal_above_threshold,
  input  wire logic       pll_unlocked,
  input  wire logic       tx_byte_request,
  output logic [7:0]      tx_byte,
  output logic            tx_byte_valid,
  output logic            tx_add_framing,
  input  wire logic       tx_bits_pending,
  input  wire logic       tx_final_bit
);
  import radio_fifo_pkg::*;

  localparam int PW = $clog2(DEPTH);

  // pointers wrap on their own only for a power-of-two array; the 64-byte length code needs at least 64
  initial begin
    if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two of at least 64");
    end
  end

  // ---------------- serial port, link clock domain ----------------
  logic         spi_rst_n;
  logic [3:0]   bit_count;
  logic [7:0]   in_shift;
  logic [7:0]   cfg_hdr;
  logic [7:0]   cfg_wdata;
  logic [7:0]   data_wbyte;
  logic [1:0]   spi_tgl;
  logic [7:0]   out_shift;
  logic [7:0]   byte_now;
  logic         cfg_frame;
  logic         data_frame;
  // images read by the link side; head_image and img_ctl reload on every enabled system clock, even mid-read
  logic [7:0]   img_ctl;
  logic [7:0]   head_image;
  logic [7:0]   fifo_size_threshold;
  logic [7:0]   irq_pin_mapping;

  // config select overrides data select
  assign cfg_frame  = ~nss_config_n;
  assign data_frame = nss_config_n & ~nss_data_n;
  assign byte_now   = {in_shift[6:0], mosi};
  // bit counter dies with the frame; the link clock stops between frames
  assign spi_rst_n  = arst_n & ~(nss_config_n & nss_data_n);
  assign miso_oe    = cfg_frame | data_frame;
  assign miso       = (bit_count == 4'h0) ? (data_frame & head_image[7]) : out_shift[7];

  // sample on the rising link edge
  always_ff @(posedge spi_clk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bit_count <= 4'h0;
      in_shift  <= 8'h00;
    end else begin
      in_shift  <= byte_now;
      bit_count <= bit_count + 4'h1;
    end
  end

  // completed write words are held and announced by a toggle; the header is only held
  always_ff @(posedge spi_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_hdr    <= 8'h00;
      cfg_wdata  <= 8'h00;
      data_wbyte <= 8'h00;
      spi_tgl    <= 2'b00;
    end else if (cfg_frame) begin
      if (bit_count == spi_hdr_last) begin
        cfg_hdr <= byte_now;
      end
      if (bit_count == spi_data_last && !cfg_hdr[spi_read_bit]) begin
        cfg_wdata  <= byte_now;
        spi_tgl[0] <= ~spi_tgl[0];
      end
    end else if (data_frame && bit_count[2:0] == 3'h7) begin
      data_wbyte <= byte_now;
      spi_tgl[1] <= ~spi_tgl[1];
    end
  end

  // shift out on the falling edge; a data frame reloads a fresh head_image byte every eight bits
  always_ff @(negedge spi_clk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      out_shift <= 8'h00;
    end else if (cfg_frame && bit_count == spi_rd_load) begin
      unique case (cfg_hdr[4:0])
        addr_fifo_size_threshold:     out_shift <= fifo_size_threshold;
        addr_irq_pin_mapping:         out_shift <= irq_pin_mapping;
        addr_irq_fifo_control_status: out_shift <= img_ctl;
        default:                      out_shift <= 8'h00;
      endcase
    end else if (data_frame && bit_count[2:0] == 3'h1) begin
      out_shift <= {head_image[6:0], 1'b0};
    end else if (data_frame && bit_count[2:0] == 3'h0) begin
      out_shift <= head_image;
    end else begin
      out_shift <= {out_shift[6:0], 1'b0};
    end
  end

  // ---------------- crossing into the system clock ----------------
  logic [1:0] tgl_s1;
  logic [1:0] tgl_s2;
  logic [1:0] tgl_s3;
  logic [1:0] tgl_seen;
  logic [1:0] tgl_agree;
  logic [1:0] spi_evt;

  // a change counts once the second and third stages agree
  assign tgl_agree = ~(tgl_s2 ^ tgl_s3);
  assign spi_evt   = tgl_agree & (tgl_s3 ^ tgl_seen);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s1   <= 2'b00;
      tgl_s2   <= 2'b00;
      tgl_s3   <= 2'b00;
      tgl_seen <= 2'b00;
    end else if (ce) begin
      tgl_s1   <= spi_tgl;
      tgl_s2   <= tgl_s1;
      tgl_s3   <= tgl_s2;
      tgl_seen <= (tgl_seen & ~tgl_agree) | (tgl_s3 & tgl_agree);
    end
  end

  // ---------------- registers ----------------
  logic       cfg_wr;
  logic       ctl_wr;
  logic [7:0] ctl_bits;
  logic       overflow;
  logic       fifo_reset;
  logic       armed;
  logic       fill_auto;
  logic       fill_enable;
  logic       in_rx;
  logic       in_tx;

  assign cfg_wr     = spi_evt[0];
  assign ctl_wr     = cfg_wr && cfg_hdr[4:0] == addr_irq_fifo_control_status;
  assign fifo_reset = ctl_wr && cfg_wdata[ctl_overflow];
  assign in_rx      = operating_mode_field == mode_receive;
  assign in_tx      = operating_mode_field == mode_transmit;
  assign fill_enable = ctl_bits[ctl_fill_manual] ? ctl_bits[ctl_fill_start] : fill_auto;

  // software-written configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_size_threshold <= rst_fifo_size_threshold;
      irq_pin_mapping     <= rst_irq_pin_mapping;
      ctl_bits            <= rst_irq_fifo_control_status;
    end else if (ce && cfg_wr) begin
      if (cfg_hdr[4:0] == addr_fifo_size_threshold) begin
        fifo_size_threshold <= cfg_wdata;
      end
      if (cfg_hdr[4:0] == addr_irq_pin_mapping) begin
        irq_pin_mapping <= cfg_wdata;
      end
      if (ctl_wr) begin
        ctl_bits <= cfg_wdata & 8'hc9; // only 7, 6, 3, 0 are stored
      end
    end
  end

  // arming and automatic fill; fill never outlives the receive mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed     <= 1'b0;
      fill_auto <= 1'b0;
    end else if (ce) begin
      if (!in_rx) begin
        fill_auto <= 1'b0;
      end else if (armed && start_pattern_detect) begin
        fill_auto <= 1'b1;
      end
      if (ctl_wr && cfg_wdata[ctl_fill_start]) begin
        armed <= 1'b1;
      end else if (in_rx && start_pattern_detect) begin
        armed <= 1'b0;
      end
    end
  end

  // ---------------- fifo ----------------
  logic [7:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic [PW:0]   capacity;
  logic [PW:0]   threshold;
  logic        spi_write_dir;
  logic        push_rx;
  logic        push;
  logic        pop;
  logic        tx_pop;
  logic        full;
  logic        not_empty;
  logic        store;
  logic        take;

  // usable length in 16-byte steps; the code never selects beyond the array
  assign capacity  = (PW + 1)'({fifo_size_threshold[7:size_len_lsb], 4'h0}) + (PW + 1)'(fifo_unit_bytes);
  assign threshold = (PW + 1)'(fifo_size_threshold[size_thr_msb:0]) + (PW + 1)'(1);
  assign full      = count >= capacity;
  assign not_empty = count != '0;
  assign spi_write_dir = in_tx || (operating_mode_field == mode_standby && !standby_fifo_read);
  assign push_rx   = in_rx && fill_enable && rx_byte_valid;
  assign tx_pop    = in_tx && tx_byte_request && not_empty;
  assign push      = push_rx || (spi_evt[1] && spi_write_dir);
  assign pop       = tx_pop || (spi_evt[1] && !spi_write_dir);
  assign store     = push && !full;
  assign take      = pop && not_empty;

  // storage and pointers; a full fifo drops the byte and flags overflow
  always_ff @(posedge clk) begin
    if (ce && store) begin
      mem[wr_ptr] <= push_rx ? rx_byte : data_wbyte;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (fifo_reset) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (store) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (take) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
        count <= count + (PW + 1)'(store) - (PW + 1)'(take);
      end
    end
  end

  // overflow: a new overflow in the clearing cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow <= 1'b0;
    end else if (ce) begin
      if (push && full) begin
        overflow <= 1'b1;
      end else if (fifo_reset) begin
        overflow <= 1'b0;
      end
    end
  end

  // data toward the modulator; framer adds preamble, pattern, checksum
  assign tx_add_framing = packet_mode;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_byte       <= 8'h00;
      tx_byte_valid <= 1'b0;
      head_image    <= 8'h00;
    end else if (ce) begin
      tx_byte_valid <= tx_pop;
      if (tx_pop) begin
        tx_byte <= mem[rd_ptr];
      end
      head_image <= mem[rd_ptr];
    end
  end

  // ---------------- events and interrupt routing ----------------
  function automatic logic addr_ok(input logic [1:0] policy, input logic [7:0] own,
                                   input logic [7:0] adr);
    unique case (policy)
      2'b00:   addr_ok = 1'b1;
      2'b01:   addr_ok = adr == own;
      2'b10:   addr_ok = adr == own || adr == 8'h00;
      default: addr_ok = adr == own || adr == 8'h00 || adr == 8'hff;
    endcase
  endfunction : addr_ok

  logic rx_thr_evt;
  logic tx_thr_evt;
  logic rssi_evt;
  logic tx_done;
  logic next_irq_a;
  logic next_irq_b;

  assign address_accept = rx_address_valid && addr_ok(address_filter, own_address, rx_address);
  assign rx_thr_evt = in_rx && count >= threshold;
  assign tx_thr_evt = in_tx && count <= threshold;
  assign rssi_evt   = ctl_bits[ctl_rssi_enable] && signal_above_threshold;
  assign tx_done    = !not_empty && !tx_bits_pending;

  // selector decode per mode
  always_comb begin
    next_irq_a = 1'b0;
    next_irq_b = 1'b0;
    if (in_rx) begin
      unique case (irq_pin_mapping[map_a_rx_lsb +: 2])
        2'b00: next_irq_a = packet_mode && data_ready;
        2'b01: next_irq_a = push_rx && store;
        2'b10: next_irq_a = not_empty;
        2'b11: next_irq_a = start_pattern_detect || (packet_mode && address_accept);
      endcase
      unique case (irq_pin_mapping[map_b_rx_lsb +: 2])
        2'b00: next_irq_b = packet_mode && crc_ok;
        2'b01: next_irq_b = full;
        2'b10: next_irq_b = rssi_evt;
        2'b11: next_irq_b = rx_thr_evt;
      endcase
    end else if (in_tx) begin
      next_irq_a = irq_pin_mapping[map_a_tx_bit] ? tx_thr_evt : not_empty;
      next_irq_b = irq_pin_mapping[map_b_tx_bit] ? tx_final_bit : full;
    end
  end

  // outputs registered; status image for the link side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_interrupt_a <= 1'b0;
      host_interrupt_b <= 1'b0;
      lock_pin         <= 1'b1;
      img_ctl          <= 8'h00;
    end else if (ce) begin
      host_interrupt_a <= next_irq_a;
      host_interrupt_b <= next_irq_b;
      lock_pin         <= ctl_bits[ctl_lock_off] || !pll_unlocked;
      img_ctl          <= {ctl_bits[ctl_fill_manual],
                           ctl_bits[ctl_fill_manual] ? ctl_bits[ctl_fill_start] : fill_auto,
                           tx_done, overflow, ctl_bits[ctl_rssi_enable],
                           signal_above_threshold, pll_unlocked, ctl_bits[ctl_lock_off]};
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  count_bound_a: assert property (count <= capacity)
    else $error("byte count above selected length");
  count_step_a: assert property (ce && store && !take && !fifo_reset |=> count == $past(count) + 1'b1)
    else $error("count did not step on write");
  overflow_set_a: assert property (ce && push && full |=> overflow)
    else $error("overflow not held after dropped write");
  fill_gate_a: assert property (ce && in_rx && !fill_enable && !take |=> count <= $past(count))
    else $error("byte stored before fill enabled");
  rx_threshold_a: assert property (ce && in_rx && irq_pin_mapping[5:4] == 2'b11
                                   && count >= threshold |=> host_interrupt_b)
    else $error("receive threshold not routed");
  tx_threshold_a: assert property (ce && in_tx && irq_pin_mapping[3] && count <= threshold
                                   |=> host_interrupt_a)
    else $error("transmit threshold not routed");
  tx_stop_a: assert property (ce && in_tx && irq_pin_mapping[2] && tx_final_bit
                              |=> host_interrupt_b)
    else $error("stop event not routed");
  empty_low_a: assert property (ce && in_tx && !irq_pin_mapping[3] && count == '0
                                |=> !host_interrupt_a)
    else $error("not-empty high on empty fifo");
  lock_force_a: assert property (ce && ctl_bits[0] |=> lock_pin)
    else $error("lock pin not forced high");

  rx_fill_c: cover property (in_rx && push_rx ##1 host_interrupt_a);
  overflow_c: cover property (push && full ##[1:20] fifo_reset);
  tx_stop_c: cover property (in_tx && tx_final_bit ##1 host_interrupt_b);
  cfg_write_c: cover property (ctl_wr);
endmodule : radio_fifo_irq

// [verification/host_spi_model.sv]
module host_spi_model (
  output logic      spi_clk,
  output logic      nss_config_n,
  output logic      nss_data_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  // link clock stands low and both selects stay high between frames
  initial begin
    spi_clk = 1'b0;
    nss_config_n = 1'b1;
    nss_data_n = 1'b1;
    mosi = 1'b0;
  end

  // one frame msb first at a 30 ns link period; mosi moves only while spi_clk is low
  task automatic frame(input logic cfg, input int nbits, input logic [15:0] dout,
                       output logic [15:0] din);
    int i;
    din = 16'h0000;
    if (cfg) begin
      nss_config_n = 1'b0;
    end else begin
      nss_data_n = 1'b0;
    end
    for (i = nbits - 1; i >= 0; i--) begin
      mosi = dout[i];
      #15 spi_clk = 1'b1;
      din[i] = miso; // mode 0: sample on the rising edge
      #15 spi_clk = 1'b0;
    end
    #15;
    nss_config_n = 1'b1;
    nss_data_n = 1'b1;
    mosi = ~mosi; // released line never shows the last bit
  endtask : frame
endmodule : host_spi_model

// [verification/tb_radio_fifo_irq.sv]
module tb_radio_fifo_irq;
  timeunit 1ns;
  timeprecision 100ps;
  import radio_fifo_pkg::*;

`define check(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

  logic       clk, arst_n, ce, spi_clk, nss_config_n, nss_data_n, mosi, miso, miso_oe;
  logic       host_interrupt_a, host_interrupt_b, lock_pin, packet_mode, standby_fifo_read;
  logic       rx_byte_valid, start_pattern_detect, rx_address_valid, address_accept;
  logic       crc_ok, data_ready, signal_above_threshold, pll_unlocked, tx_byte_request;
  logic       tx_byte_valid, tx_add_framing, tx_bits_pending, tx_final_bit;
  logic [2:0] operating_mode_field;
  logic [1:0] address_filter;
  logic [7:0] rx_byte, own_address, rx_address, tx_byte, d, b;
  logic [7:0] q[$];
  int         err_count, total_checks, cycles, len, thr, seed, i, lc, c, k, hits;

  radio_fifo_irq #(.DEPTH(64)) uut (
    .clk(clk), .arst_n(arst_n), .ce(ce), .spi_clk(spi_clk), .nss_config_n(nss_config_n),
    .nss_data_n(nss_data_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .host_interrupt_a(host_interrupt_a), .host_interrupt_b(host_interrupt_b),
    .lock_pin(lock_pin), .operating_mode_field(operating_mode_field),
    .packet_mode(packet_mode), .standby_fifo_read(standby_fifo_read),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .start_pattern_detect(start_pattern_detect), .own_address(own_address),
    .address_filter(address_filter), .rx_address_valid(rx_address_valid),
    .rx_address(rx_address), .address_accept(address_accept), .crc_ok(crc_ok),
    .data_ready(data_ready), .signal_above_threshold(signal_above_threshold),
    .pll_unlocked(pll_unlocked), .tx_byte_request(tx_byte_request), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .tx_add_framing(tx_add_framing),
    .tx_bits_pending(tx_bits_pending), .tx_final_bit(tx_final_bit));

  host_spi_model host (.spi_clk(spi_clk), .nss_config_n(nss_config_n),
    .nss_data_n(nss_data_n), .mosi(mosi), .miso(miso));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard, well above the expected run length
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 30000) begin
        err_count++;
        end_of_test();
      end
    end
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // system-side inputs move 2 ns after a rising edge; the link signals follow the host model's own 15 ns steps
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  // 12 cycles of gap covers the 4..6 cycle landing plus the frame spacing
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [15:0] r;
    host.frame(1'b1, 16, {3'h0, a, v}, r);
    cyc(12);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    logic [15:0] r;
    host.frame(1'b1, 16, {3'h4, a, 8'h00}, r);
    v = r[7:0];
    cyc(12);
  endtask : rd

  task automatic push(input logic [7:0] v);
    logic [15:0] r;
    host.frame(1'b0, 8, {8'h00, v}, r);
    cyc(12);
    if (q.size() < len) begin
      q.push_back(v);
    end
  endtask : push

  task automatic pop_port();
    logic [15:0] r;
    host.frame(1'b0, 8, 16'h0000, r);
    cyc(12);
    `check(r[7:0], q.pop_front())
  endtask : pop_port

  // modulator asks for one byte; valid must pulse exactly once
  task automatic tx_pop();
    int n;
    n = 0;
    tx_byte_request = 1'b1;
    cyc(1);
    tx_byte_request = 1'b0;
    repeat (3) begin
      if (tx_byte_valid === 1'b1) begin
        n++;
        `check(tx_byte, q[0])
      end
      cyc(1);
    end
    void'(q.pop_front());
    `check(n, 1)
  endtask : tx_pop

  // one demodulated byte; write pulses are counted over three cycles
  task automatic rx_send(input logic store);
    rx_byte = 8'($random(seed));
    rx_byte_valid = 1'b1;
    cyc(1);
    rx_byte_valid = 1'b0;
    hits = 0;
    repeat (3) begin
      if (host_interrupt_a === 1'b1) hits++;
      cyc(1);
    end
    if (store) q.push_back(rx_byte);
    `check(hits, int'(store))
    `check(host_interrupt_b, q.size() >= thr)
  endtask : rx_send

  initial begin
    seed = 15;
    {arst_n, packet_mode, standby_fifo_read, rx_byte_valid, start_pattern_detect} = '0;
    {rx_address_valid, crc_ok, data_ready, signal_above_threshold, pll_unlocked} = '0;
    {tx_byte_request, tx_bits_pending, tx_final_bit, address_filter} = '0;
    {rx_byte, rx_address} = '0;
    ce = 1'b1;
    own_address = {1'b0, 6'($random(seed)), 1'b1}; // never 0x00 or 0xff
    operating_mode_field = mode_standby;
    err_count = 0;
    total_checks = 0;
    cyc(10);
    arst_n = 1'b1;
    cyc(5);
    `check(miso_oe, 1'b0)
    // reset values, status bits masked, and an unmapped address
    rd(addr_fifo_size_threshold, d);
    `check(d, rst_fifo_size_threshold)
    rd(addr_irq_pin_mapping, d);
    `check(d, rst_irq_pin_mapping)
    rd(addr_irq_fifo_control_status, d);
    `check(d & 8'hc9, rst_irq_fifo_control_status & 8'hc9)
    wr(5'h1f, 8'h5a);
    rd(5'h1f, d);
    `check(d, 8'h00)
    // transmit: every length code, filled past full, then drained (codes 0, 2) or cleared by reset (codes 1, 3)
    operating_mode_field = mode_synth;
    cyc(3);
    `check(lock_pin, 1'b1)
    operating_mode_field = mode_transmit;
    wr(addr_irq_pin_mapping, 8'h08);
    for (lc = 0; lc < 4; lc++) begin
      packet_mode = lc[0];
      len = 16 * (lc + 1);
      k = {$random(seed)} % len;
      thr = k + 1;
      wr(addr_fifo_size_threshold, {lc[1:0], k[5:0]});
      `check(tx_add_framing, packet_mode)
      for (i = 0; i <= len; i++) begin
        b = (!packet_mode && i < 3) ? 8'haa : 8'($random(seed));
        push(b);
        `check(host_interrupt_a, q.size() <= thr)
        `check(host_interrupt_b, q.size() == len)
      end
      rd(addr_irq_fifo_control_status, d);
      `check(d[ctl_overflow], 1'b1)
      if (lc[0]) begin
        wr(addr_irq_fifo_control_status, 8'h10); // clear while full
        q.delete();
        `check(host_interrupt_b, 1'b0)
      end
      tx_bits_pending = 1'b1;
      while (q.size() > 0) tx_pop();
      `check(host_interrupt_a, 1'b1)
      rd(addr_irq_fifo_control_status, d);
      `check(d[ctl_tx_done], 1'b0)
      tx_bits_pending = 1'b0;
      wr(addr_irq_fifo_control_status, 8'h10);
      rd(addr_irq_fifo_control_status, d);
      `check(d[ctl_tx_done], 1'b1)
      `check(d[ctl_overflow], 1'b0)
    end
    // stop event on the second output, not-empty on the first
    wr(addr_irq_pin_mapping, 8'h04);
    `check(host_interrupt_a, 1'b0)
    tx_final_bit = 1'b1;
    cyc(1);
    tx_final_bit = 1'b0;
    hits = 0;
    repeat (3) begin
      if (host_interrupt_b === 1'b1) hits++;
      cyc(1);
    end
    `check(hits, 1)
    cyc(2); // one 50 ns bit period before standby
    // buffered receive: arm, ignore bytes before the pattern, then fill
    operating_mode_field = mode_standby;
    packet_mode = 1'b0;
    len = 64;
    thr = 4;
    wr(addr_fifo_size_threshold, 8'hc3);
    wr(addr_irq_pin_mapping, 8'h70);
    wr(addr_irq_fifo_control_status, 8'h40);
    operating_mode_field = mode_synth;
    cyc(3);
    operating_mode_field = mode_receive;
    repeat (2) rx_send(1'b0);
    start_pattern_detect = 1'b1;
    cyc(1);
    start_pattern_detect = 1'b0;
    cyc(2);
    repeat (6) rx_send(1'b1);
    // frozen clock enable: a byte offered now must not be stored
    ce = 1'b0;
    rx_byte_valid = 1'b1;
    cyc(2);
    rx_byte_valid = 1'b0;
    ce = 1'b1;
    cyc(2);
    wr(addr_irq_fifo_control_status, 8'h80); // manual, stopped
    rx_send(1'b0);
    wr(addr_irq_fifo_control_status, 8'hc0); // manual, filling
    rx_send(1'b1);
    operating_mode_field = mode_standby;
    standby_fifo_read = 1'b1;
    while (q.size() > 0) pop_port();
    // packet receive: every selector code, address policies, status levels
    packet_mode = 1'b1; // 64-byte fifo covers any payload
    operating_mode_field = mode_synth;
    cyc(3);
    operating_mode_field = mode_receive;
    for (c = 0; c < 4; c++) begin
      {crc_ok, data_ready, signal_above_threshold, pll_unlocked} = 4'($random(seed));
      wr(addr_irq_fifo_control_status, 8'h08);
      wr(addr_irq_pin_mapping, {c[1:0], c[1:0], 4'h0});
      `check(host_interrupt_a, (c == 0) ? data_ready : 1'b0)
      `check(host_interrupt_b, (c == 0) ? crc_ok : (c == 2) ? signal_above_threshold : 1'b0)
      rd(addr_irq_fifo_control_status, d);
      `check(d[ctl_rssi_level], signal_above_threshold)
      `check(d[ctl_pll_unlock], pll_unlocked)
      `check(lock_pin, ~pll_unlocked)
      address_filter = c[1:0];
      for (k = 0; k < 4; k++) begin
        rx_address = (k == 0) ? own_address : (k == 1) ? 8'h00 : (k == 2) ? 8'hff : ~own_address;
        rx_address_valid = 1'b1;
        #1;
        `check(address_accept, c == 0 || k == 0 || (c >= 2 && k == 1) || (c == 3 && k == 2))
        cyc(1);
        rx_address_valid = 1'b0;
      end
    end
    pll_unlocked = 1'b1;
    wr(addr_irq_fifo_control_status, 8'h01);
    `check(lock_pin, 1'b1)
    end_of_test();
  end
endmodule : tb_radio_fifo_irq
